//--- src/mcrs_core_ram.sv
// Notes on behaviour
// - reset is taken only after the pin stays high 24 oscillator periods, while still high; the ram clear starts after it falls
// - reset clears every byte of the internal data ram to zero
// - power-down stops the oscillator after the requesting instruction completes
// - idle drives strobes 1, ports hold; power-down drives strobes 0, port zero resets with ext_program, else holds
// - bytes 00h to 1fh form four banks of eight working registers
// - bank 0 is active after reset until software selects another
// - stack pointer resets to 07h and increments before each push
// - bytes 20h to 2fh hold 128 individually addressable bits 00h to 7fh
// - bit n lives in byte 20h plus n/8, bit n mod 8
// - bit-area bytes are byte-accessible and coherent with bit accesses
// - bytes 30h to 7fh are general scratch storage
// - all 128 bytes are reachable by direct and indirect addressing
`timescale 1ns/100ps
`default_nettype none
`include "mcrs_defines.svh"
module mcrs_core_ram #(
    parameter int unsigned RST_CYCLES = `MCRS_RST_OSC_PERIODS
) (
    input  wire logic       mclk,
    input  wire logic       rst_n,
    input  wire logic       reset_pin,
    input  wire logic       ext_program,
    input  wire logic       idle_req,
    input  wire logic       pdown_req,
    input  wire logic       wake_evt,
    input  wire logic       bank_we,
    input  wire logic [1:0] bank_wdata,
    input  wire logic       sp_we,
    input  wire logic [7:0] sp_wdata,
    input  wire logic       push_req,
    input  wire logic [7:0] push_data,
    input  wire logic       pop_req,
    input  wire logic       dir_we,
    input  wire logic       dir_re,
    input  wire logic [6:0] dir_addr,
    input  wire logic [7:0] dir_wdata,
    input  wire logic       ind_we,
    input  wire logic       ind_re,
    input  wire logic       ind_sel,
    input  wire logic [7:0] ind_wdata,
    input  wire logic       reg_we,
    input  wire logic [2:0] reg_num,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       bit_we,
    input  wire logic [6:0] bit_addr,
    input  wire logic       bit_wdata,
    input  wire logic [7:0] port0_out,
    input  wire logic [7:0] port2_out,
    input  wire logic       ale_run,
    input  wire logic       program_fetch_strobe_run,
    output logic            core_reset,
    output logic            ram_ready,
    output logic            osc_enable,
    output logic [1:0]      bank_sel,
    output logic [7:0]      stack_top_pointer,
    output logic [7:0]      rd_data,
    output logic [7:0]      reg_rdata,
    output logic            bit_rdata,
    output logic            ale,
    output logic            program_fetch_strobe,
    output logic [7:0]      port0_pin,
    output logic [7:0]      port2_pin,
    output logic [1:0]      power_mode
);
    localparam int unsigned CNT_W = $clog2(RST_CYCLES + 1);
    localparam int unsigned DEPTH = `MCRS_RAM_DEPTH;
    // ==========================================================
    // reset pin synchroniser and qualifier
    logic             rsync1_q;
    logic             rsync2_q;
    logic [CNT_W-1:0] hcnt_q, hcnt_d;
    logic             armed_q, armed_d;
    logic             qual_rst;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rsync1_q <= 1'b0;
            rsync2_q <= 1'b0;
        end else begin
            rsync1_q <= reset_pin;
            rsync2_q <= rsync1_q;
        end
    end
    always_comb begin
        hcnt_d   = hcnt_q;
        armed_d  = armed_q;
        qual_rst = 1'b0;
        if (rsync2_q) begin
            if (hcnt_q != CNT_W'(RST_CYCLES))
                hcnt_d = hcnt_q + CNT_W'(1);
            if (hcnt_q == CNT_W'(RST_CYCLES - 1))
                armed_d = 1'b1;
        end else begin
            hcnt_d = '0;
            if (armed_q) begin
                qual_rst = 1'b1;
                armed_d  = 1'b0;
            end
        end
    end
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            hcnt_q  <= '0;
            armed_q <= 1'b0;
        end else begin
            hcnt_q  <= hcnt_d;
            armed_q <= armed_d;
        end
    end
    // ==========================================================
    // reset sequencer: ram clear walk
    mcrs_pkg::mcrs_rst_state_t rst_st_q, rst_st_d;
    logic [6:0]                clr_idx_q, clr_idx_d;
    always_comb begin
        rst_st_d  = rst_st_q;
        clr_idx_d = clr_idx_q;
        unique case (rst_st_q)
            mcrs_pkg::MCRS_RST_ACTIVE: begin
                clr_idx_d = '0;
                rst_st_d  = mcrs_pkg::MCRS_RST_CLEAR;
            end
            mcrs_pkg::MCRS_RST_CLEAR: begin
                clr_idx_d = clr_idx_q + 7'h01;
                if (clr_idx_q == 7'(DEPTH - 1))
                    rst_st_d = mcrs_pkg::MCRS_RST_READY;
            end
            mcrs_pkg::MCRS_RST_READY: ;
        endcase
        if (qual_rst || armed_q)
            rst_st_d = mcrs_pkg::MCRS_RST_ACTIVE;
    end
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rst_st_q  <= mcrs_pkg::MCRS_RST_ACTIVE;
            clr_idx_q <= '0;
        end else begin
            rst_st_q  <= rst_st_d;
            clr_idx_q <= clr_idx_d;
        end
    end
    logic in_reset;
    assign in_reset   = (rst_st_q != mcrs_pkg::MCRS_RST_READY);
    assign core_reset = in_reset;
    assign ram_ready  = !in_reset;
    // ==========================================================
    // power modes
    mcrs_pkg::mcrs_pmode_t pm_q, pm_d;
    always_comb begin
        pm_d = pm_q;
        unique case (pm_q)
            mcrs_pkg::MCRS_RUN: begin
                if (pdown_req)
                    pm_d = mcrs_pkg::MCRS_PDOWN;
                else if (idle_req)
                    pm_d = mcrs_pkg::MCRS_IDLE;
            end
            mcrs_pkg::MCRS_IDLE: begin
                if (wake_evt)
                    pm_d = mcrs_pkg::MCRS_RUN;
            end
            mcrs_pkg::MCRS_PDOWN: ;
            default: pm_d = mcrs_pkg::MCRS_RUN;
        endcase
        if (in_reset)
            pm_d = mcrs_pkg::MCRS_RUN;
    end
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n)
            pm_q <= mcrs_pkg::MCRS_RUN;
        else
            pm_q <= pm_d;
    end
    logic active;
    assign active     = !in_reset && (pm_q == mcrs_pkg::MCRS_RUN);
    assign power_mode = pm_q;
    assign osc_enable = (pm_q != mcrs_pkg::MCRS_PDOWN);
    // ==========================================================
    // pin levels
    logic       ale_d, pfs_d;
    logic [7:0] p0_d, p2_d;
    logic       ale_q, pfs_q;
    logic [7:0] p0_q, p2_q;
    always_comb begin
        ale_d = ale_run;
        pfs_d = program_fetch_strobe_run;
        p0_d  = port0_out;
        p2_d  = port2_out;
        unique case (pm_q)
            mcrs_pkg::MCRS_RUN: ;
            mcrs_pkg::MCRS_IDLE: begin
                ale_d = `MCRS_STROBE_IDLE;
                pfs_d = `MCRS_STROBE_IDLE;
                p0_d  = p0_q;
                p2_d  = p2_q;
            end
            // power-down strobes low, port zero reset with ext_program, else held
            mcrs_pkg::MCRS_PDOWN: begin
                ale_d = `MCRS_STROBE_PD;
                pfs_d = `MCRS_STROBE_PD;
                p0_d  = ext_program ? `MCRS_PORT0_RESET : p0_q;
                p2_d  = p2_q;
            end
            default: ;
        endcase
        if (in_reset) begin
            p0_d = `MCRS_PORT0_RESET;
            p2_d = `MCRS_PORT0_RESET;
        end
    end
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ale_q <= `MCRS_STROBE_IDLE;
            pfs_q <= `MCRS_STROBE_IDLE;
            p0_q  <= `MCRS_PORT0_RESET;
            p2_q  <= `MCRS_PORT0_RESET;
        end else begin
            ale_q <= ale_d;
            pfs_q <= pfs_d;
            p0_q  <= p0_d;
            p2_q  <= p2_d;
        end
    end
    assign ale                  = ale_q;
    assign program_fetch_strobe = pfs_q;
    assign port0_pin            = p0_q;
    assign port2_pin            = p2_q;
    // ==========================================================
    // bank select and stack pointer
    logic [1:0] bank_q, bank_d;
    logic [7:0] sp_q, sp_d;
    always_comb begin
        bank_d = bank_q;
        sp_d   = sp_q;
        if (in_reset) begin
            bank_d = '0;
            sp_d   = `MCRS_SP_RESET;
        end else if (active) begin
            if (bank_we)
                bank_d = bank_wdata;
            if (sp_we)
                sp_d = sp_wdata;
            else if (push_req)
                sp_d = sp_q + 8'h01;
            else if (pop_req)
                sp_d = sp_q - 8'h01;
        end
    end
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            bank_q <= '0;
            sp_q   <= `MCRS_SP_RESET;
        end else begin
            bank_q <= bank_d;
            sp_q   <= sp_d;
        end
    end
    assign bank_sel          = bank_q;
    assign stack_top_pointer = sp_q;
    // ==========================================================
    // internal ram: direct, indirect, register, bit and stack ports
    logic [7:0] ram_q [DEPTH];
    logic [7:0] ram_d [DEPTH];
    logic [6:0] reg_addr, ind_addr, push_addr, bit_byte;
    logic [2:0] bit_pos;
    logic [7:0] rd_d, rd_q, regr_d, regr_q;
    logic       bitr_d, bitr_q;
    assign reg_addr  = {2'b00, bank_q, reg_num};
    // indirect pointer is r0 or r1 of the active bank
    assign ind_addr  = ram_q[{2'b00, bank_q, 2'b00, ind_sel}][6:0];
    // stack grows from the pointer upward, including scratch area
    assign push_addr = sp_d[6:0];
    // bit n to byte 20h + n/8
    assign bit_byte  = `MCRS_BIT_BASE + {3'b000, bit_addr[6:3]};
    assign bit_pos   = bit_addr[2:0];
    always_comb begin
        ram_d  = ram_q;
        rd_d   = rd_q;
        regr_d = ram_q[reg_addr];
        // bit reads from the shared byte storage
        bitr_d = ram_q[bit_byte][bit_pos];
        if (in_reset) begin
            if (rst_st_q == mcrs_pkg::MCRS_RST_CLEAR)
                ram_d[clr_idx_q] = `MCRS_RAM_RESET;
            rd_d = '0;
        end else if (active) begin
            if (dir_re)
                rd_d = ram_q[dir_addr];
            else if (ind_re)
                rd_d = ram_q[ind_addr];
            else if (pop_req && !push_req)
                rd_d = ram_q[sp_q[6:0]];
            if (dir_we)
                ram_d[dir_addr] = dir_wdata;
            if (ind_we)
                ram_d[ind_addr] = ind_wdata;
            if (reg_we)
                ram_d[reg_addr] = reg_wdata;
            // single bit write in bit area
            if (bit_we)
                ram_d[bit_byte][bit_pos] = bit_wdata;
            if (push_req && !sp_we)
                ram_d[push_addr] = push_data;
        end
    end
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < DEPTH; i++)
                ram_q[i] <= `MCRS_RAM_RESET;
            rd_q   <= '0;
            regr_q <= '0;
            bitr_q <= 1'b0;
        end else begin
            ram_q  <= ram_d;
            rd_q   <= rd_d;
            regr_q <= regr_d;
            bitr_q <= bitr_d;
        end
    end
    assign rd_data   = rd_q;
    assign reg_rdata = regr_q;
    assign bit_rdata = bitr_q;
endmodule : mcrs_core_ram
`default_nettype wire

//--- src/mcrs_defines.svh
`ifndef MCRS_DEFINES_SVH
`define MCRS_DEFINES_SVH

// ram layout
`define MCRS_RAM_DEPTH     128
`define MCRS_ADDR_W        7
`define MCRS_BANK_W        2
`define MCRS_BIT_BASE      7'h20
`define MCRS_BIT_ADDR_W    7
`define MCRS_SCRATCH_BASE  7'h30
`define MCRS_RAM_RESET     8'h00

// stack pointer
`define MCRS_SP_RESET      8'h07

// reset qualification: two machine cycles of twelve oscillator periods
`define MCRS_RST_OSC_PERIODS 24

// strobe levels
`define MCRS_STROBE_IDLE   1'b1
`define MCRS_STROBE_PD     1'b0
`define MCRS_PORT0_RESET   8'hff

`endif

//--- src/mcrs_pkg.sv
package mcrs_pkg;

    typedef enum logic [1:0] {
        MCRS_RUN,
        MCRS_IDLE,
        MCRS_PDOWN
    } mcrs_pmode_t;

    typedef enum logic [1:0] {
        MCRS_RST_ACTIVE,
        MCRS_RST_CLEAR,
        MCRS_RST_READY
    } mcrs_rst_state_t;

endpackage : mcrs_pkg

//--- dv/mcrs_core_ram_monitor.sv
`timescale 1ns/100ps
`default_nettype none
// ==========
// port checker
module mcrs_core_ram_monitor #(
    parameter int unsigned RST_CYCLES = 24
) (
    input wire logic       mclk,
    input wire logic       rst_n,
    input wire logic       reset_pin,
    input wire logic       ext_program,
    input wire logic       idle_req,
    input wire logic       pdown_req,
    input wire logic       bank_we,
    input wire logic       sp_we,
    input wire logic       push_req,
    input wire logic       pop_req,
    input wire logic       core_reset,
    input wire logic       ram_ready,
    input wire logic       osc_enable,
    input wire logic [1:0] bank_sel,
    input wire logic [7:0] stack_top_pointer,
    input wire logic       ale,
    input wire logic       program_fetch_strobe,
    input wire logic [7:0] port0_pin,
    input wire logic [7:0] port2_pin,
    input wire logic [1:0] power_mode
);
    logic [5:0] hi_cnt_q, hi_cnt_d;
    logic       long_q, long_d;

    // length of the current high run on the reset pin
    always_comb begin
        hi_cnt_d = reset_pin ? hi_cnt_q + {5'h00, hi_cnt_q != 6'h3f} : 6'h00;
        long_d   = !core_reset && (long_q || 32'(hi_cnt_q) >= RST_CYCLES);
    end
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            hi_cnt_q <= 6'h00;
            long_q   <= 1'b0;
        end else begin
            hi_cnt_q <= hi_cnt_d;
            long_q   <= long_d;
        end
    end

    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);

    sequence s_taken(req);
        ram_ready && power_mode == 2'h0 && req;
    endsequence
    sequence s_pd_settled;
        power_mode == 2'h2 ##1 power_mode == 2'h2;
    endsequence

    property p_osc_off; power_mode == 2'h2 |-> !osc_enable; endproperty
    property p_push;
        s_taken(push_req && !sp_we && !pop_req && !idle_req && !pdown_req) |=>
            core_reset || stack_top_pointer == $past(stack_top_pointer) + 8'h01;
    endproperty
    property p_rst_vals; $rose(ram_ready) |-> stack_top_pointer == 8'h07 && bank_sel == 2'h0;
    endproperty
    property p_bank;
        $changed(bank_sel) |-> core_reset || $past(bank_we && ram_ready && power_mode == 2'h0);
    endproperty
    property p_idle;
        power_mode == 2'h1 && $past(power_mode) == 2'h1 |-> ale && program_fetch_strobe;
    endproperty
    property p_pd_pins;
        s_pd_settled ##0 ext_program |-> !ale && !program_fetch_strobe && port0_pin == 8'hff;
    endproperty
    property p_port2; s_pd_settled |=> $stable(port2_pin); endproperty
    property p_rst_len; $rose(core_reset) |-> long_q; endproperty

    a_osc_off: assert property (p_osc_off)
        else $error("oscillator runs in power-down");
    a_push: assert property (p_push)
        else $error("push did not advance the stack pointer by one");
    a_rst_vals: assert property (p_rst_vals)
        else $error("wrong pointer or bank after reset");
    a_bank: assert property (p_bank)
        else $error("bank changed without a select");
    a_idle: assert property (p_idle)
        else $error("strobes not high in idle");
    a_pd_pins: assert property (p_pd_pins)
        else $error("wrong strobe or port zero level in power-down");
    a_port2: assert property (p_port2)
        else $error("port two moved in power-down");
    a_rst_len: assert property (p_rst_len)
        else $error("reset taken after a short pulse");
endmodule : mcrs_core_ram_monitor

bind mcrs_core_ram mcrs_core_ram_monitor #(.RST_CYCLES(RST_CYCLES)) u_mon (
    .mclk, .rst_n, .reset_pin, .ext_program, .idle_req, .pdown_req, .bank_we, .sp_we,
    .push_req, .pop_req, .core_reset, .ram_ready, .osc_enable, .bank_sel,
    .stack_top_pointer, .ale, .program_fetch_strobe, .port0_pin, .port2_pin, .power_mode
);
`default_nettype wire

//--- dv/tb_mcu_core_ram_reset_state.sv
`timescale 1ns/100ps
`default_nettype none
module tb_mcu_core_ram_reset_state;
    typedef struct packed {logic [6:0] a; logic [7:0] d;} mcrs_row_t;
    logic       mclk, rst_n, reset_pin, ext_program, idle_req, pdown_req, wake_evt, bank_we;
    logic       sp_we, push_req, pop_req, dir_we, dir_re, ind_we, ind_re, ind_sel, reg_we;
    logic       bit_we, bit_wdata, ale_run, pfs_run, core_reset, ram_ready, osc_enable;
    logic       bit_rdata, ale, program_fetch_strobe;
    logic [1:0] bank_wdata, bank_sel, power_mode;
    logic [2:0] reg_num;
    logic [6:0] dir_addr, bit_addr;
    logic [7:0] sp_wdata, push_data, dir_wdata, ind_wdata, reg_wdata, port0_out, port2_out;
    logic [7:0] stack_top_pointer, rd_data, reg_rdata, port0_pin, port2_pin;
    int         num_errors = 0;
    int         cmp_count = 0;
    mcrs_row_t  rows [6] = '{'{7'h07, 8'h11}, '{7'h1f, 8'h22}, '{7'h20, 8'h33},
                             '{7'h2f, 8'h44}, '{7'h30, 8'h5c}, '{7'h7f, 8'h66}};

    mcrs_core_ram u_dut (
        .mclk, .rst_n, .reset_pin, .ext_program, .idle_req, .pdown_req, .wake_evt,
        .bank_we, .bank_wdata, .sp_we, .sp_wdata, .push_req, .push_data, .pop_req,
        .dir_we, .dir_re, .dir_addr, .dir_wdata, .ind_we, .ind_re, .ind_sel, .ind_wdata,
        .reg_we, .reg_num, .reg_wdata, .bit_we, .bit_addr, .bit_wdata, .port0_out,
        .port2_out, .ale_run, .program_fetch_strobe_run(pfs_run), .core_reset, .ram_ready,
        .osc_enable, .bank_sel, .stack_top_pointer, .rd_data, .reg_rdata, .bit_rdata, .ale,
        .program_fetch_strobe, .port0_pin, .port2_pin, .power_mode
    );

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    // ==========
    // helpers
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : tally_and_finish
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : cyc
    task automatic wait_ready;
        int i;
        for (i = 0; i < 400 && ram_ready !== 1'b1; i++) cyc(1);
        if (ram_ready !== 1'b1) begin
            num_errors++;
            tally_and_finish();
        end
    endtask : wait_ready
    task automatic dir_wr(input logic [6:0] a, input logic [7:0] d);
        @(posedge mclk);
        {dir_we, dir_addr, dir_wdata} <= {1'b1, a, d};
        @(posedge mclk);
        dir_we <= 1'b0;
    endtask : dir_wr
    task automatic dir_rd(input logic [6:0] a, input logic [7:0] e);
        @(posedge mclk);
        {dir_re, dir_addr} <= {1'b1, a};
        @(posedge mclk);
        dir_re <= 1'b0;
        #1 chk(rd_data, e);
    endtask : dir_rd

    // ==========
    // main sequence
    initial begin
        {rst_n, reset_pin, ext_program, idle_req, pdown_req, wake_evt, bank_we, sp_we,
         push_req, pop_req, dir_we, dir_re, ind_we, ind_re, ind_sel, reg_we, bit_we, bit_wdata,
         ale_run, pfs_run, bank_wdata, reg_num, dir_addr, bit_addr, sp_wdata, push_data,
         dir_wdata, ind_wdata, reg_wdata, port0_out, port2_out} = '0;
        repeat (5) @(posedge mclk);
        rst_n <= 1'b1;
        wait_ready();
        chk(stack_top_pointer, 8'h07);
        chk({6'h00, bank_sel}, 8'h00);
        dir_rd(7'h7f, 8'h00);
        foreach (rows[i]) dir_wr(rows[i].a, rows[i].d);
        foreach (rows[i]) dir_rd(rows[i].a, rows[i].d);
        @(posedge mclk);
        reg_num <= 3'h7;
        cyc(2);
        chk(reg_rdata, 8'h11);
        @(posedge mclk);
        {bit_we, bit_addr, bit_wdata} <= {1'b1, 7'h09, 1'b1};
        @(posedge mclk);
        bit_we <= 1'b0;
        dir_rd(7'h21, 8'h02);
        dir_wr(7'h21, 8'h80);
        @(posedge mclk);
        bit_addr <= 7'h0f;
        cyc(2);
        chk({7'h00, bit_rdata}, 8'h01);
        @(posedge mclk);
        {reg_we, reg_num, reg_wdata} <= {1'b1, 3'h0, 8'h30};
        @(posedge mclk);
        {reg_we, ind_re} <= 2'b01;
        @(posedge mclk);
        ind_re <= 1'b0;
        #1 chk(rd_data, 8'h5c);
        @(posedge mclk);
        {push_req, push_data} <= {1'b1, 8'haa};
        @(posedge mclk);
        push_req <= 1'b0;
        #1 chk(stack_top_pointer, 8'h08);
        dir_rd(7'h08, 8'haa);
        @(posedge mclk);
        pop_req <= 1'b1;
        @(posedge mclk);
        pop_req <= 1'b0;
        #1 chk(rd_data, 8'haa);
        @(posedge mclk);
        {bank_we, bank_wdata} <= {1'b1, 2'h1};
        @(posedge mclk);
        {bank_we, reg_we, reg_num, reg_wdata} <= {2'b01, 3'h1, 8'h55};
        @(posedge mclk);
        reg_we <= 1'b0;
        dir_rd(7'h09, 8'h55);
        @(posedge mclk);
        {ind_we, ind_sel, ind_wdata} <= {2'b11, 8'h6e};
        @(posedge mclk);
        ind_we <= 1'b0;
        dir_rd(7'h55, 8'h6e);
        @(posedge mclk);
        {sp_we, sp_wdata} <= {1'b1, 8'h4f};
        @(posedge mclk);
        {sp_we, push_req, push_data} <= {2'b01, 8'hb7};
        @(posedge mclk);
        push_req <= 1'b0;
        #1 chk(stack_top_pointer, 8'h50);
        dir_rd(7'h50, 8'hb7);
        @(posedge mclk);
        reset_pin <= 1'b1;
        repeat (10) @(posedge mclk);
        reset_pin <= 1'b0;
        cyc(40);
        chk({7'h00, ram_ready}, 8'h01);
        @(posedge mclk);
        idle_req <= 1'b1;
        @(posedge mclk);
        idle_req <= 1'b0;
        cyc(2);
        chk({4'h0, power_mode, ale, program_fetch_strobe}, 8'h07);
        dir_wr(7'h30, 8'h5a);
        @(posedge mclk);
        wake_evt <= 1'b1;
        @(posedge mclk);
        wake_evt <= 1'b0;
        cyc(2);
        dir_rd(7'h30, 8'h5c);
        @(posedge mclk);
        {ale_run, pfs_run, ext_program, port2_out, pdown_req} <= {3'b111, 8'h3c, 1'b1};
        @(posedge mclk);
        {pdown_req, port2_out} <= {1'b0, 8'hc3};
        cyc(3);
        chk({4'h0, power_mode, osc_enable, ale}, 8'h08);
        chk({7'h00, program_fetch_strobe}, 8'h00);
        chk(port0_pin, 8'hff);
        chk(port2_pin, 8'h3c);
        @(posedge mclk);
        rst_n <= 1'b0;
        repeat (2) @(posedge mclk);
        rst_n <= 1'b1;
        wait_ready();
        chk({5'h00, power_mode, osc_enable}, 8'h01);
        chk({6'h00, bank_sel}, 8'h00);
        dir_wr(7'h7f, 8'h99);
        @(posedge mclk);
        reset_pin <= 1'b1;
        repeat (30) @(posedge mclk);
        reset_pin <= 1'b0;
        cyc(4);
        chk({7'h00, core_reset}, 8'h01);
        wait_ready();
        dir_rd(7'h7f, 8'h00);
        chk(stack_top_pointer, 8'h07);
        @(posedge mclk);
        {ext_program, port0_out, pdown_req} <= {1'b0, 8'ha5, 1'b1};
        @(posedge mclk);
        {pdown_req, port0_out} <= {1'b0, 8'h5a};
        cyc(3);
        chk(port0_pin, 8'ha5);
        chk({6'h00, power_mode}, 8'h02);
        tally_and_finish();
    end
endmodule : tb_mcu_core_ram_reset_state
`default_nettype wire
